// *** common/rpmc_pkg.sv ***
// Constants and types shared by the reset and power mode controller
package rpmc_pkg;
	// Special function register addresses
	localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
	localparam logic [7:0] RCAUSE_ADDR = 8'hEF;
	// Power control fields
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int GPF_LSB = 2;
	localparam logic [7:0] PWR_CTRL_RST = 8'h00;
	// Reset cause fields
	localparam int CAUSE_PIN_BIT = 0;
	localparam int CAUSE_POR_BIT = 1;
	localparam int CAUSE_MCD_BIT = 2;
	localparam int CAUSE_WDT_BIT = 3;
	localparam int CAUSE_SW_BIT = 4;
	localparam int CAUSE_VDD_BIT = 5;
	localparam int FORCE_POR_BIT = 0;
	localparam logic [7:0] RCAUSE_RST = 8'h00;
	// Values applied by reset
	localparam logic [7:0] PORT_RST = 8'hFF;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [3:0] WDT_DIV = 4'hC;
	localparam logic [1:0] PIN_MASK_CYC = 2'h3;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int POR_DELAY_NS = 300000;
	localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_POR,
		ST_RST,
		ST_RUN,
		ST_IDLE,
		ST_STOP
	} rpmc_state_t;
endpackage : rpmc_pkg

// *** hdl/rpmc_por_timer.sv ***
// Power-on delay counter, restarted by a held start level
`timescale 1ns/1ps
module rpmc_por_timer #(
	parameter int CYCLES = rpmc_pkg::POR_DELAY_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Control
	input wire logic i_start,
	output logic o_done
);
	localparam logic [15:0] LAST = 16'(CYCLES - 1);

	typedef struct packed {
		logic [15:0] cnt;
		logic done;
	} rpmc_tmr_t;

	rpmc_tmr_t s_q;
	rpmc_tmr_t s_d;

	always_comb begin
		s_d = s_q;
		if (i_start) begin
			s_d.cnt = 16'h0000;
			s_d.done = 1'b0;
		end else if (!s_q.done) begin
			if (s_q.cnt == LAST) begin
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_done = s_q.done;
endmodule : rpmc_por_timer

// *** hdl/rpmc_top.sv ***
// Reset sequencing, reset cause tracking and idle/stop control
// Notes on behaviour
// - Any reset stops the processor from fetching until reset ends.
// - Reset loads all special function registers except the reset cause register with their reset values.
// - Reset forces port pins known and disables interrupts and timers.
// - Data memory is untouched by reset; the stack pointer is still reset.
// - Port latches go to 0xFF open-drain; weak pull-ups stay on.
// - Power-on and supply monitor resets drive the reset pin low.
// - Leaving reset clears the program counter and selects internal oscillator.
// - Leaving reset enables the watchdog, clocked by system clock over 12.
// - Every reset restarts fetching at address 0x0000.
// - After supply is good, hold reset a further power-on delay.
// - Leaving power-on reset sets the power-on cause flag.
// - Other resets clear the power-on flag; other flags then undefined.
// - Power-on reset enables the supply voltage monitor.
// - Writing one to the forced power-on bit causes a full power-on reset.
// - Idle bit halts the CPU after the writing instruction; clocks run.
// - An enabled interrupt ends idle; execution continues after the setter.
// - Stop bit halts CPU, oscillator and peripherals; only reset ends it.
`timescale 1ns/1ps
module rpmc_top #(
	parameter int POR_CYCLES = rpmc_pkg::POR_DELAY_CYC
) (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// Reset sources
	input wire logic i_rst_pin_i,
	input wire logic i_vdd_low,
	input wire logic i_wdt_rst,
	input wire logic i_mcd_rst,
	input wire logic i_sw_rst,
	// Processor handshake
	input wire logic i_irq_wake,
	input wire logic i_instr_done,
	// Special function register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	// Reset pin, open-drain
	output logic o_rst_pin_o,
	output logic o_rst_pin_oe,
	// System controls
	output logic o_cpu_fetch_en,
	output logic o_sfr_init,
	output logic o_irq_tmr_disable,
	output logic o_port_load,
	output logic [7:0] o_port_latch,
	output logic o_port_open_drain,
	output logic o_weak_pullup_en,
	output logic o_pc_load,
	output logic [15:0] o_pc_value,
	output logic o_clk_sel_int,
	output logic o_wdt_en,
	output logic [3:0] o_wdt_div,
	output logic o_vdm_en,
	output logic o_idle_active,
	output logic o_osc_stop,
	output logic o_periph_stop
);
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] pin_sync;
		logic [1:0] vdd_sync;
		rpmc_pkg::rpmc_state_t st;
		logic force_por;
		logic pend_idle;
		logic pend_stop;
		logic [5:0] gpf;
		logic [7:0] cause;
		logic vdm_en;
		logic wdt_en;
		logic [1:0] pin_mask;
		logic rst_pin_drv;
		logic [7:0] rdata;
		logic cpu_run;
		logic in_reset;
		logic idle_act;
		logic stop_act;
	} rpmc_state_reg_t;

	rpmc_state_reg_t s_q;
	rpmc_state_reg_t s_d;
	logic por_req;
	logic tmr_done;

	// Forced power-on shares the supply path, so both get the full delay
	assign por_req = !s_q.rst_sync[1] || s_q.force_por;

	rpmc_por_timer #(
		.CYCLES(POR_CYCLES)
	) u_por_timer (
		.i_clk(i_mclk),
		.i_rst_n(s_q.rst_sync[1]),
		.i_ce(i_ce),
		.i_start(por_req),
		.o_done(tmr_done)
	);

	always_comb begin
		logic [7:0] src;
		logic wr_pwr;
		logic wr_cause;
		src = 8'h00;
		wr_pwr = 1'b0;
		wr_cause = 1'b0;
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
		s_d.pin_sync = {s_q.pin_sync[0], i_rst_pin_i};
		s_d.vdd_sync = {s_q.vdd_sync[0], i_vdd_low};
		s_d.force_por = 1'b0;
		if (s_q.pin_mask != 2'h0) begin
			s_d.pin_mask = s_q.pin_mask - 2'h1;
		end
		// Our own drive of the pin echoes back late; mask it after release
		src[rpmc_pkg::CAUSE_PIN_BIT] = !s_q.pin_sync[1] && (s_q.pin_mask == 2'h0);
		src[rpmc_pkg::CAUSE_VDD_BIT] = s_q.vdd_sync[1] && s_q.vdm_en;
		src[rpmc_pkg::CAUSE_MCD_BIT] = i_mcd_rst;
		src[rpmc_pkg::CAUSE_WDT_BIT] = i_wdt_rst;
		src[rpmc_pkg::CAUSE_SW_BIT] = i_sw_rst;
		wr_pwr = i_sfr_wr && (i_sfr_addr == rpmc_pkg::PWR_CTRL_ADDR)
			&& (s_q.st == rpmc_pkg::ST_RUN);
		wr_cause = i_sfr_wr && (i_sfr_addr == rpmc_pkg::RCAUSE_ADDR)
			&& (s_q.st == rpmc_pkg::ST_RUN);

		if (por_req) begin
			s_d.st = rpmc_pkg::ST_POR;
			s_d.gpf = rpmc_pkg::PWR_CTRL_RST[7:2];
			s_d.pend_idle = 1'b0;
			s_d.pend_stop = 1'b0;
			s_d.wdt_en = 1'b0;
		end else if ((src != 8'h00) && (s_q.st != rpmc_pkg::ST_POR)) begin
			// Reset ends idle and stop alike
			if (s_q.st != rpmc_pkg::ST_RST) begin
				s_d.cause = 8'h00;
			end
			s_d.cause = s_d.cause | src;
			s_d.st = rpmc_pkg::ST_RST;
			s_d.gpf = rpmc_pkg::PWR_CTRL_RST[7:2];
			s_d.pend_idle = 1'b0;
			s_d.pend_stop = 1'b0;
			s_d.wdt_en = 1'b0;
		end else begin
			case (s_q.st)
				rpmc_pkg::ST_POR: begin
					if (tmr_done) begin
						s_d.st = rpmc_pkg::ST_RUN;
						s_d.cause[rpmc_pkg::CAUSE_POR_BIT] = 1'b1;
						s_d.vdm_en = 1'b1;
						s_d.wdt_en = 1'b1;
						s_d.pin_mask = rpmc_pkg::PIN_MASK_CYC;
					end
				end
				rpmc_pkg::ST_RST: begin
					s_d.st = rpmc_pkg::ST_RUN;
					s_d.wdt_en = 1'b1;
					s_d.pin_mask = rpmc_pkg::PIN_MASK_CYC;
				end
				rpmc_pkg::ST_RUN: begin
					if (wr_pwr) begin
						s_d.gpf = i_sfr_wdata[7:rpmc_pkg::GPF_LSB];
						s_d.pend_idle = i_sfr_wdata[rpmc_pkg::IDLE_BIT];
						s_d.pend_stop = i_sfr_wdata[rpmc_pkg::STOP_BIT];
					end
					if (wr_cause && i_sfr_wdata[rpmc_pkg::FORCE_POR_BIT]) begin
						s_d.force_por = 1'b1;
					end
					// Entry waits for the writing instruction to retire
					if (i_instr_done && s_d.pend_stop) begin
						s_d.st = rpmc_pkg::ST_STOP;
						s_d.pend_stop = 1'b0;
						s_d.pend_idle = 1'b0;
					end else if (i_instr_done && s_d.pend_idle) begin
						s_d.st = rpmc_pkg::ST_IDLE;
						s_d.pend_idle = 1'b0;
					end
				end
				rpmc_pkg::ST_IDLE: begin
					if (i_irq_wake) begin
						s_d.st = rpmc_pkg::ST_RUN;
					end
				end
				rpmc_pkg::ST_STOP: begin
					s_d.st = rpmc_pkg::ST_STOP;
				end
				default: begin
					s_d.st = rpmc_pkg::ST_POR;
				end
			endcase
		end

		// Registered view of the next state drives the reset, run, idle, stop and reset pin outputs
		s_d.in_reset = (s_d.st == rpmc_pkg::ST_POR) || (s_d.st == rpmc_pkg::ST_RST);
		s_d.cpu_run = (s_d.st == rpmc_pkg::ST_RUN);
		s_d.idle_act = (s_d.st == rpmc_pkg::ST_IDLE);
		s_d.stop_act = (s_d.st == rpmc_pkg::ST_STOP);
		s_d.rst_pin_drv = (s_d.st == rpmc_pkg::ST_POR)
			|| ((s_d.st == rpmc_pkg::ST_RST) && s_d.cause[rpmc_pkg::CAUSE_VDD_BIT]);

		s_d.rdata = 8'h00;
		if (i_sfr_rd && (i_sfr_addr == rpmc_pkg::PWR_CTRL_ADDR)) begin
			s_d.rdata = {s_q.gpf, 2'b00};
		end else if (i_sfr_rd && (i_sfr_addr == rpmc_pkg::RCAUSE_ADDR)) begin
			s_d.rdata = s_q.cause;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= '0;
			s_q.st <= rpmc_pkg::ST_POR;
			s_q.cause <= rpmc_pkg::RCAUSE_RST;
			s_q.pin_sync <= 2'b11;
			s_q.rst_pin_drv <= 1'b1;
			s_q.in_reset <= 1'b1;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_sfr_rdata = s_q.rdata;
	assign o_rst_pin_o = 1'b0;
	assign o_rst_pin_oe = s_q.rst_pin_drv;
	assign o_cpu_fetch_en = s_q.cpu_run;
	// Stack pointer is among the reloaded registers; data memory gets no clear
	assign o_sfr_init = s_q.in_reset;
	assign o_irq_tmr_disable = s_q.in_reset;
	assign o_port_load = s_q.in_reset;
	assign o_port_latch = rpmc_pkg::PORT_RST;
	assign o_port_open_drain = s_q.in_reset;
	assign o_weak_pullup_en = 1'b1;
	assign o_pc_load = s_q.in_reset;
	assign o_pc_value = rpmc_pkg::RESET_VECTOR;
	assign o_clk_sel_int = s_q.in_reset;
	assign o_wdt_en = s_q.wdt_en;
	assign o_wdt_div = rpmc_pkg::WDT_DIV;
	assign o_vdm_en = s_q.vdm_en;
	assign o_idle_active = s_q.idle_act;
	assign o_osc_stop = s_q.stop_act;
	assign o_periph_stop = s_q.stop_act;
endmodule : rpmc_top

// *** test/rpmc_top_assertions.sv ***
// Port-level checks for the reset and power mode controller
`timescale 1ns/1ps
module rpmc_top_assertions (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// Requests
	input wire logic i_rst_pin_i,
	input wire logic i_vdd_low,
	input wire logic i_wdt_rst,
	input wire logic i_mcd_rst,
	input wire logic i_sw_rst,
	input wire logic i_irq_wake,
	input wire logic i_instr_done,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	// Observed
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_rst_pin_o,
	input wire logic o_rst_pin_oe,
	input wire logic o_cpu_fetch_en,
	input wire logic o_sfr_init,
	input wire logic o_irq_tmr_disable,
	input wire logic o_port_load,
	input wire logic [7:0] o_port_latch,
	input wire logic o_weak_pullup_en,
	input wire logic [15:0] o_pc_value,
	input wire logic o_wdt_en,
	input wire logic [3:0] o_wdt_div,
	input wire logic o_idle_active,
	input wire logic o_osc_stop
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	wire quiet = !i_wdt_rst && !i_mcd_rst && !i_sw_rst;
	// Pin and supply inputs pass a synchroniser, so they must be calm for a while
	sequence s_calm;
		(i_rst_pin_i && !i_vdd_low && quiet && i_ce)[*3];
	endsequence
	sequence s_idle_wr;
		o_cpu_fetch_en && i_sfr_wr && i_sfr_addr == 8'h87 && i_sfr_wdata[1:0] == 2'b01;
	endsequence
	a_fetch_in_reset: assert property (o_cpu_fetch_en |-> !o_sfr_init)
		else $error("fetch during reset");
	a_reset_group: assert property (o_sfr_init == o_irq_tmr_disable && o_sfr_init == o_port_load)
		else $error("reset controls differ");
	a_port_values: assert property (o_port_latch == 8'hFF && o_weak_pullup_en && o_pc_value == 16'h0000)
		else $error("port or vector value");
	a_pin_drive: assert property (o_rst_pin_oe |-> o_sfr_init && !o_rst_pin_o)
		else $error("reset pin drive");
	a_wdt_entry: assert property (o_cpu_fetch_en && i_ce && i_wdt_rst |=> o_sfr_init && !o_cpu_fetch_en && !o_wdt_en)
		else $error("watchdog reset entry");
	a_wdt_on_exit: assert property ($fell(o_sfr_init) |-> o_wdt_en && o_wdt_div == 4'hC)
		else $error("watchdog not enabled at exit");
	a_idle_entry: assert property (s_calm ##0 s_idle_wr ##0 i_instr_done |=> o_idle_active && !o_cpu_fetch_en)
		else $error("idle not entered");
	a_idle_wake: assert property (s_calm ##0 o_idle_active && i_irq_wake |=> o_cpu_fetch_en && !o_idle_active)
		else $error("idle not ended");
	a_stop_holds: assert property (s_calm ##0 o_osc_stop |=> o_osc_stop && !o_cpu_fetch_en)
		else $error("stop left without reset");
	a_mode_bits_zero: assert property (i_ce && i_sfr_rd && i_sfr_addr == 8'h87 |=> o_sfr_rdata[1:0] == 2'b00)
		else $error("mode bits read nonzero");
endmodule : rpmc_top_assertions

// *** test/tb_rpmc_top.sv ***
// Testbench for the reset and power mode controller
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module tb_rpmc_top;
	logic i_mclk = 0, i_resetn = 0, i_ce = 1, i_rst_pin_i = 1, i_vdd_low = 0;
	logic i_irq_wake = 0, i_instr_done = 0, i_sfr_wr = 0, i_sfr_rd = 0;
	logic i_wdt_rst, i_mcd_rst, i_sw_rst;
	logic [2:0] rq = 3'h0;
	logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, o_port_latch, rd;
	logic o_rst_pin_o, o_rst_pin_oe, o_cpu_fetch_en, o_sfr_init, o_irq_tmr_disable, o_port_load;
	logic o_port_open_drain, o_weak_pullup_en, o_pc_load, o_clk_sel_int, o_wdt_en, o_vdm_en;
	logic o_idle_active, o_osc_stop, o_periph_stop;
	logic [15:0] o_pc_value;
	logic [3:0] o_wdt_div;
	logic [5:0] cause_exp [3] = '{6'h08, 6'h04, 6'h10};
	int fail_count = 0, num_checks = 0, n, i;
	assign {i_sw_rst, i_mcd_rst, i_wdt_rst} = rq;
	always #10 i_mclk = ~i_mclk;
	// Short power-on delay keeps the run brief
	rpmc_top #(.POR_CYCLES(8)) i_rpmc_top (.*);
	task automatic conclude;
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic tick(input int k = 1);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done = 0);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1;
		i_instr_done = done;
		tick();
		i_sfr_wr = 0;
		i_instr_done = 0;
	endtask : wr
	task automatic rdt(input logic [7:0] a);
		i_sfr_addr = a;
		i_sfr_rd = 1;
		tick();
		rd = o_sfr_rdata;
		i_sfr_rd = 0;
		// One idle edge so back-to-back reads never re-raise the strobe at once
		tick();
	endtask : rdt
	task automatic waitrun;
		for (n = 0; n < 100 && o_cpu_fetch_en !== 1'b1; n++)
			tick();
		`CHK(o_cpu_fetch_en, 1'b1)
		if (o_cpu_fetch_en !== 1'b1)
			conclude();
	endtask : waitrun
	initial begin
		tick(5);
		i_resetn = 1;
		tick();
		`CHK({o_sfr_init, o_rst_pin_oe, o_cpu_fetch_en}, 3'b110)
		`CHK({o_port_open_drain, o_pc_load, o_clk_sel_int, o_pc_value}, 19'h7_0000)
		waitrun();
		`CHK({o_wdt_en, o_vdm_en, o_sfr_init, o_rst_pin_oe}, 4'b1100)
		`CHK({o_port_open_drain, o_pc_load, o_clk_sel_int}, 3'b000)
		rdt(8'hEF);
		`CHK(rd[1], 1'b1)
		rdt(8'h87);
		`CHK(rd, 8'h00)
		rdt(8'h00);
		`CHK(rd, 8'h00)
		wr(8'h87, 8'hFC);
		rdt(8'h87);
		`CHK(rd, 8'hFC)
		wr(8'h87, 8'hFD, 1);
		tick();
		`CHK({o_idle_active, o_cpu_fetch_en, o_osc_stop}, 3'b100)
		// Writes while idle must be ignored
		wr(8'h87, 8'h00);
		i_irq_wake = 1;
		tick(2);
		i_irq_wake = 0;
		`CHK({o_idle_active, o_cpu_fetch_en}, 2'b01)
		rdt(8'h87);
		`CHK(rd, 8'hFC)
		for (i = 0; i < 3; i++) begin
			rq[i] = 1;
			tick(2);
			`CHK({o_sfr_init, o_cpu_fetch_en, o_rst_pin_oe, o_wdt_en}, 4'b1000)
			rq = 3'h0;
			waitrun();
			rdt(8'hEF);
			`CHK(rd[5:0], cause_exp[i])
			rdt(8'h87);
			`CHK(rd, 8'h00)
		end
		`CHK(o_vdm_en, 1'b1)
		// Supply monitor reset drives the pin; pin reset does not
		i_vdd_low = 1;
		tick(4);
		`CHK({o_sfr_init, o_cpu_fetch_en, o_rst_pin_oe}, 3'b101)
		i_vdd_low = 0;
		waitrun();
		rdt(8'hEF);
		`CHK(rd[5:0], 6'h20)
		i_rst_pin_i = 0;
		tick(4);
		`CHK({o_sfr_init, o_cpu_fetch_en, o_rst_pin_oe}, 3'b100)
		i_rst_pin_i = 1;
		waitrun();
		rdt(8'hEF);
		`CHK(rd[5:0], 6'h01)
		wr(8'h87, 8'h02, 1);
		i_irq_wake = 1;
		tick(4);
		`CHK({o_osc_stop, o_periph_stop, o_cpu_fetch_en}, 3'b110)
		i_irq_wake = 0;
		rq[2] = 1;
		tick(2);
		rq = 3'h0;
		waitrun();
		`CHK(o_osc_stop, 1'b0)
		wr(8'hEF, 8'h01);
		tick(2);
		`CHK({o_rst_pin_oe, o_cpu_fetch_en}, 2'b10)
		waitrun();
		rdt(8'hEF);
		`CHK(rd[1], 1'b1)
		conclude();
	end
endmodule : tb_rpmc_top
bind rpmc_top rpmc_top_assertions i_rpmc_top_assertions (.*);
